/* verilog/clm_pkg.sv */
// package for the companion link master: register map, field positions,
// reset values, link timing counts, state codes and shared functions.
// assumes a single system clock that also serves as the link master clock.
package clm_pkg;

  // clocking
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned LINK_CLK_MAX_HZ = 3_000_000;
  // half period lasts divider+1 cycles, so the floor keeps the link at or under its maximum
  localparam logic [7:0] LINK_DIV_MIN =
    8'((SYS_CLK_HZ + 2 * LINK_CLK_MAX_HZ - 1) / (2 * LINK_CLK_MAX_HZ) - 1);

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_DIVIDER = 8'h0c;

  // status field positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_BCIE_BIT = 4;
  localparam int unsigned ST_EIE_BIT = 5;
  localparam int unsigned ST_ERR_BIT = 6;
  localparam int unsigned ST_RST_BIT = 7;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h81;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h04;

  // link timing, in link clocks
  localparam logic [5:0] TAR_CLOCKS = 6'd2;
  localparam logic [5:0] TIMEOUT_CLOCKS = 6'd16;
  localparam logic [5:0] RECOVER_CLOCKS = 6'd48;
  localparam logic [5:0] SOFT_RESET_CLOCKS = 6'd48;

  // framing: bits sent after the start bit, bits received after the response start bit
  localparam logic [5:0] WRITE_TX_REST = 6'd21;
  localparam logic [5:0] READ_TX_REST = 6'd13;
  localparam logic [5:0] RX_BITS = 6'd12;
  localparam logic CMD_READ = 1'b1;
  localparam logic CMD_WRITE = 1'b0;
  localparam logic [3:0] CRC_INIT = 4'hf;
  localparam logic [3:0] CRC_POLY = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT_OUT = 3'b001,
    ST_TURN = 3'b010,
    ST_WAIT_START = 3'b011,
    ST_SHIFT_IN = 3'b100,
    ST_RECOVER = 3'b101,
    ST_SOFT_RST = 3'b110
  } clm_state_t;

  // crc over a 17-bit field, x^4+x+1, msb first
  function automatic logic [3:0] clm_crc4(input logic [16:0] bits);
    logic [3:0] crc;
    logic fb;
    crc = CRC_INIT;
    fb = 1'b0;
    for (int i = 16; i >= 0; i--) begin
      fb = crc[3] ^ bits[i];
      crc = {crc[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    return crc;
  endfunction

  // register address decode
  function automatic logic clm_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

endpackage

/* verilog/clm_phy_if.sv */
// interface between the transaction core and the link clock/pin stage.
// assumes both ends sit on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface clm_phy_if;
  logic [7:0] divider; // link clock divider from the core
  logic run; // link clock runs while high
  logic link_clk; // link clock level, a flop
  logic tick_rise; // pulse with each rising link edge
  logic tick_fall; // pulse with each falling link edge
  logic data_in; // synchronised data line
  logic irq_n; // synchronised companion request, active low
  modport phy (input divider, run, output link_clk, tick_rise, tick_fall, data_in, irq_n);
  modport core (output divider, run, input link_clk, tick_rise, tick_fall, data_in, irq_n);
endinterface
`default_nettype wire

/* verilog/clm_link_phy.sv */
// link clock divider and input synchronisers for the companion link master.
// assumes the pins arrive asynchronously and the core drives divider and run.
`timescale 1ns/1ns
`default_nettype none
module clm_link_phy
  import clm_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic link_data_in, // data pin, raw
  input wire logic companion_irq_n_in, // companion request pin, raw
  clm_phy_if.phy port // to the core
);

  logic [7:0] div_cnt;
  logic [7:0] div_eff;
  logic data_meta;
  logic irq_meta;

  ////////////////////////////////////////////////////////////////////////
  // a low divider would overrun the link, so clamp it to the floor
  assign div_eff = (port.divider < LINK_DIV_MIN) ? LINK_DIV_MIN : port.divider;

  // divide the system clock down into the link clock;
  // compare with >= so a divider lowered mid-count never wraps the counter
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt <= 8'h00;
      port.link_clk <= 1'b0;
      port.tick_rise <= 1'b0;
      port.tick_fall <= 1'b0;
    end else if (!port.run) begin
      div_cnt <= 8'h00; // parked low between transfers
      port.link_clk <= 1'b0;
      port.tick_rise <= 1'b0;
      port.tick_fall <= 1'b0;
    end else if (div_cnt >= div_eff) begin
      div_cnt <= 8'h00;
      port.link_clk <= ~port.link_clk;
      port.tick_rise <= ~port.link_clk;
      port.tick_fall <= port.link_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      port.tick_rise <= 1'b0;
      port.tick_fall <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_meta <= 1'b1;
      port.data_in <= 1'b1;
      irq_meta <= 1'b1;
      port.irq_n <= 1'b1;
    end else begin
      data_meta <= link_data_in;
      port.data_in <= data_meta;
      irq_meta <= companion_irq_n_in;
      port.irq_n <= irq_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // frames end on a rising edge, after which the clock parks low at once
  AST_LINK_HALF_PERIOD: assert property ($rose(port.link_clk) |=>
                                         ($stable(port.link_clk) || !port.run)[*4])
    else $error("link clock high phase shorter than the floor");

endmodule
`default_nettype wire

/* verilog/clm_link_master.sv */
// companion link master: register file, read sequencer and transaction engine.
// assumes a simple register port on the system clock and a pulled-up data line.
`timescale 1ns/1ns
`default_nettype none
module clm_link_master
  import clm_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic reset_n_in, // watchdog reset, active low
  input wire logic [7:0] reg_addr_in, // register byte offset
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  input wire logic [31:0] reg_wdata_in, // register write data
  output logic [31:0] reg_rdata_out, // read data, valid the cycle after the strobe
  output logic link_clock_out, // link clock pin
  input wire logic link_data_in, // data pin input side
  output logic link_data_out, // data pin output value
  output logic link_data_oe_out, // data pin driven while high
  input wire logic companion_irq_n_in, // companion request pin, active low
  output logic busy_cleared_irq_out, // one-cycle busy-cleared event
  output logic link_error_irq_out, // gated error level
  output logic companion_irq_n_out // synchronised companion request, active low
);

  clm_phy_if phy_bus();

  clm_state_t state;
  logic [5:0] count;
  logic [20:0] tx_shift;
  logic [10:0] rx_shift;
  logic is_read;
  logic soft_reset;
  logic link_error;
  logic error_irq_enable;
  logic busy_cleared_irq_enable;
  logic rd_phase2;
  logic [7:0] link_target_address;
  logic [7:0] link_data_byte;
  logic [7:0] link_clock_divider;
  logic busy_now;
  logic wr_launch;
  logic rd_launch;
  logic sr_req;
  logic err_clr;
  logic [11:0] rx_word;
  logic rx_last;
  logic crc_ok;
  logic rx_load;
  logic ack_seen;
  logic recover_done;
  logic sr_done;
  logic hw_done;

  clm_link_phy u_phy (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .link_data_in(link_data_in),
    .companion_irq_n_in(companion_irq_n_in),
    .port(phy_bus.phy)
  );

  ////////////////////////////////////////////////////////////////////////
  // request decode and completion events
  assign busy_now = soft_reset | (state != ST_IDLE);
  assign wr_launch = reg_wr_in && clm_hit(reg_addr_in, OFS_DATA) && !busy_now;
  assign rd_launch = reg_rd_in && clm_hit(reg_addr_in, OFS_DATA) && !busy_now && !rd_phase2;
  assign sr_req = reg_wr_in && clm_hit(reg_addr_in, OFS_STATUS) && reg_wdata_in[ST_RST_BIT];
  assign err_clr = reg_wr_in && clm_hit(reg_addr_in, OFS_STATUS) && reg_wdata_in[ST_ERR_BIT];
  assign rx_word = {rx_shift, phy_bus.data_in};
  assign rx_last = (state == ST_SHIFT_IN) && phy_bus.tick_rise && (count == RX_BITS - 6'd1);
  assign crc_ok = clm_crc4({9'h000, rx_word[11:4]}) == rx_word[3:0];
  assign rx_load = rx_last && crc_ok;
  assign ack_seen = (state == ST_WAIT_START) && phy_bus.tick_rise && !phy_bus.data_in && !is_read;
  assign recover_done = (state == ST_RECOVER) && phy_bus.tick_rise && (count == RECOVER_CLOCKS - 6'd1);
  assign sr_done = (state == ST_SOFT_RST) && phy_bus.tick_rise && (count == SOFT_RESET_CLOCKS - 6'd1);
  assign hw_done = rx_load || ack_seen || recover_done; // soft reset end excluded on purpose
  assign phy_bus.run = busy_now;
  assign phy_bus.divider = link_clock_divider;
  assign link_clock_out = phy_bus.link_clk;

  ////////////////////////////////////////////////////////////////////////
  // transaction engine; returns to idle on watchdog reset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      count <= 6'd0;
      tx_shift <= 21'h00000;
      rx_shift <= 11'h000;
      is_read <= CMD_WRITE;
      link_data_out <= 1'b1;
      link_data_oe_out <= 1'b1;
    end else if (soft_reset && state != ST_SOFT_RST) begin
      state <= ST_SOFT_RST;
      count <= 6'd0;
      link_data_out <= 1'b1;
      link_data_oe_out <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          link_data_out <= 1'b1;
          link_data_oe_out <= 1'b1;
          if (wr_launch) begin
            state <= ST_SHIFT_OUT;
            is_read <= CMD_WRITE;
            link_data_out <= 1'b0;
            tx_shift <= {CMD_WRITE, link_target_address, reg_wdata_in[7:0],
                         clm_crc4({CMD_WRITE, link_target_address, reg_wdata_in[7:0]})};
            count <= WRITE_TX_REST;
          end else if (rd_launch) begin
            state <= ST_SHIFT_OUT;
            is_read <= CMD_READ;
            link_data_out <= 1'b0;
            tx_shift <= {CMD_READ, link_target_address,
                         clm_crc4({CMD_READ, link_target_address, 8'h00}), 8'h00};
            count <= READ_TX_REST;
          end
        end
        ST_SHIFT_OUT: begin
          if (phy_bus.tick_fall) begin
            if (count == 6'd0) begin
              state <= ST_TURN;
              link_data_oe_out <= 1'b0;
            end else begin
              link_data_out <= tx_shift[20];
              tx_shift <= {tx_shift[19:0], 1'b0};
              count <= count - 6'd1;
            end
          end
        end
        ST_TURN: begin
          // turnaround: nobody drives the line
          if (phy_bus.tick_fall) begin
            if (count == TAR_CLOCKS - 6'd1) begin
              state <= ST_WAIT_START;
              count <= 6'd0;
            end else begin
              count <= count + 6'd1;
            end
          end
        end
        ST_WAIT_START: begin
          if (phy_bus.tick_rise) begin
            if (!phy_bus.data_in) begin
              state <= is_read ? ST_SHIFT_IN : ST_IDLE;
              count <= 6'd0;
              link_data_out <= 1'b1; // never re-drive a stale frame bit
              link_data_oe_out <= !is_read;
            end else if (count == TIMEOUT_CLOCKS - 6'd1) begin
              state <= ST_RECOVER;
              count <= 6'd0;
              link_data_out <= 1'b1;
              link_data_oe_out <= 1'b1;
            end else begin
              count <= count + 6'd1;
            end
          end
        end
        ST_SHIFT_IN: begin
          if (phy_bus.tick_rise) begin
            rx_shift <= rx_word[10:0];
            if (rx_last) begin
              // a bad crc is handled like a time-out
              state <= crc_ok ? ST_IDLE : ST_RECOVER;
              count <= 6'd0;
              link_data_out <= 1'b1;
              link_data_oe_out <= 1'b1;
            end else begin
              count <= count + 6'd1;
            end
          end
        end
        ST_RECOVER: begin
          link_data_out <= 1'b1;
          link_data_oe_out <= 1'b1;
          if (phy_bus.tick_rise) begin
            state <= recover_done ? ST_IDLE : ST_RECOVER;
            count <= recover_done ? 6'd0 : count + 6'd1;
          end
        end
        ST_SOFT_RST: begin
          link_data_out <= 1'b1;
          link_data_oe_out <= 1'b1;
          if (phy_bus.tick_rise) begin
            state <= sr_done ? ST_IDLE : ST_SOFT_RST;
            count <= sr_done ? 6'd0 : count + 6'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
          count <= 6'd0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and control bits; hardware set beats software clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      soft_reset <= STATUS_RESET[ST_RST_BIT];
      link_error <= STATUS_RESET[ST_ERR_BIT];
      error_irq_enable <= STATUS_RESET[ST_EIE_BIT];
      busy_cleared_irq_enable <= STATUS_RESET[ST_BCIE_BIT];
    end else begin
      if (sr_req)
        soft_reset <= 1'b1;
      else if (sr_done)
        soft_reset <= 1'b0;
      if (recover_done)
        link_error <= 1'b1;
      else if (err_clr)
        link_error <= 1'b0;
      if (reg_wr_in && clm_hit(reg_addr_in, OFS_STATUS)) begin
        error_irq_enable <= reg_wdata_in[ST_EIE_BIT];
        busy_cleared_irq_enable <= reg_wdata_in[ST_BCIE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address, data and divider registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_target_address <= ADDRESS_RESET;
      link_data_byte <= DATA_RESET;
      link_clock_divider <= DIVIDER_RESET;
    end else begin
      if (reg_wr_in && clm_hit(reg_addr_in, OFS_ADDRESS))
        link_target_address <= reg_wdata_in[7:0];
      if (rx_load)
        link_data_byte <= rx_word[11:4];
      else if (wr_launch)
        link_data_byte <= reg_wdata_in[7:0];
      // divider only moves while a transfer or soft reset keeps the link busy
      if (reg_wr_in && clm_hit(reg_addr_in, OFS_DIVIDER) && busy_now)
        link_clock_divider <= reg_wdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-read sequencer; firmware must pair its reads
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_phase2 <= 1'b0;
    end else if (rd_launch) begin
      rd_phase2 <= 1'b1;
    end else if (reg_rd_in && clm_hit(reg_addr_in, OFS_DATA) && !busy_now) begin
      rd_phase2 <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data; the phase-one data read just returns whatever is held
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_STATUS: reg_rdata_out <= {24'h000000, soft_reset, link_error, error_irq_enable,
                                      busy_cleared_irq_enable, 3'b000, busy_now};
        OFS_ADDRESS: reg_rdata_out <= {24'h000000, link_target_address};
        OFS_DATA: reg_rdata_out <= {24'h000000, link_data_byte};
        OFS_DIVIDER: reg_rdata_out <= {24'h000000, link_clock_divider};
        default: reg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event outputs: busy-cleared and error gated by their enables, companion request passed through
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_cleared_irq_out <= 1'b0;
      link_error_irq_out <= 1'b0;
      companion_irq_n_out <= 1'b1;
    end else begin
      busy_cleared_irq_out <= hw_done && busy_cleared_irq_enable;
      link_error_irq_out <= link_error && error_irq_enable;
      companion_irq_n_out <= phy_bus.irq_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_START_BIT: assert property (wr_launch |=> !link_data_out && link_data_oe_out
                                  && state == ST_SHIFT_OUT && busy_now)
    else $error("write launch did not drive a start bit");
  AST_TAR_RELEASE: assert property ((state == ST_TURN || state == ST_WAIT_START ||
                                     state == ST_SHIFT_IN) |-> !link_data_oe_out)
    else $error("data driver active during turnaround or response");
  AST_READ_LAUNCH: assert property (rd_launch |=> busy_now && rd_phase2)
    else $error("phase-one read did not launch");
  AST_PHASE2_READ: assert property ((reg_rd_in && clm_hit(reg_addr_in, OFS_DATA) && rd_phase2
                                     && !busy_now) |=> !rd_phase2 && reg_rdata_out[7:0] == $past(link_data_byte))
    else $error("phase-two read returned wrong data or phase");
  AST_RX_LOAD: assert property ((rx_load && !sr_req) |=> link_data_byte == $past(rx_word[11:4]) && !busy_now)
    else $error("received byte not loaded or busy stuck");
  AST_TIMEOUT_BOUND: assert property (state == ST_WAIT_START |-> count < TIMEOUT_CLOCKS)
    else $error("response wait ran past the time-out");
  AST_RECOVER_ERR: assert property ((recover_done && !sr_req) |=> link_error && !busy_now)
    else $error("recovery end did not flag the error");
  AST_BUSY_READ: assert property ((reg_rd_in && reg_addr_in == OFS_STATUS)
                                  |=> reg_rdata_out[ST_BUSY_BIT] == $past(busy_now))
    else $error("busy bit readback wrong");
  AST_IRQ_PULSE: assert property ((hw_done && busy_cleared_irq_enable) |=> busy_cleared_irq_out ##1
                                  !busy_cleared_irq_out)
    else $error("busy-cleared pulse missing or too long");
  AST_SR_NO_IRQ: assert property (sr_done |=> !busy_cleared_irq_out)
    else $error("soft reset end raised busy-cleared");
  AST_ERR_STICKY: assert property ((link_error && !err_clr) |=> link_error)
    else $error("error flag cleared without a write of one");
  AST_DIV_LOCK: assert property (!busy_now |=> $stable(link_clock_divider))
    else $error("divider changed while idle");
  AST_RECOVER_HIGH: assert property (state == ST_RECOVER |-> link_data_out && link_data_oe_out)
    else $error("data line not held high during recovery");

  COV_WRITE_ACK: cover property (ack_seen);
  COV_READ_DONE: cover property (rx_load);
  COV_TIMEOUT: cover property (recover_done);
  COV_SOFT_RESET: cover property (sr_done);

endmodule
`default_nettype wire

/* dv/clm_companion.sv */
// companion chip model: a byte array answering link writes and reads.
// assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module clm_companion
  import clm_pkg::*;
(
  input wire logic clk_in, // link clock
  input wire logic dat_in, // resolved data wire
  input wire logic mute_in, // never answer
  input wire logic bad_in, // corrupt the reply crc
  output logic oe_out, // model drives the wire
  output logic dat_out // driven value
);
  logic [7:0] mem [256];
  logic [20:0] rx;
  logic [12:0] tx;
  logic rd;
  ////////////////////////////////////////////////////////////
  // frame receiver and responder; releases right after the last sampled bit
  initial begin
    oe_out = 1'b0;
    dat_out = 1'b1;
    forever begin
      @(posedge clk_in);
      if (dat_in === 1'b0) begin
        @(posedge clk_in) rd = dat_in;
        rx = '0;
        repeat (rd ? 12 : 20) @(posedge clk_in) rx = {rx[19:0], dat_in};
        if (rd) rx = {1'b0, rx[11:4], 8'h00, rx[3:0]};
        // bad crc or muted: stay silent so the master times out
        if (!mute_in && clm_crc4({rd, rx[19:4]}) == rx[3:0]) begin
          if (!rd) mem[rx[19:12]] = rx[11:4];
          tx = {1'b0, mem[rx[19:12]], clm_crc4({9'h000, mem[rx[19:12]]}) ^ {3'b000, bad_in}};
          repeat (3) @(negedge clk_in);
          oe_out = 1'b1;
          for (int i = 12; i >= (rd ? 0 : 12); i--) begin
            if (i < 12) @(negedge clk_in);
            dat_out = tx[i];
            @(posedge clk_in);
          end
          oe_out = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the companion link master: register tasks and scenarios.
// assumes clm_companion on the far side and a pulled-up data wire.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import clm_pkg::*;
  logic sys_clk_in, reset_n_in, reg_wr_in, reg_rd_in, irq_n, mute, bad, c_oe, c_dat, l_clk, m_dat, m_oe;
  logic bc_irq, err_irq, irq_n_out;
  logic [7:0] reg_addr;
  logic [31:0] wdata, rdata, got;
  int miscompares = 0, n_tests = 0, pulses = 0, p;
  // pull-up wins when nobody drives
  wire link_wire = m_oe ? m_dat : (c_oe ? c_dat : 1'b1);
  clm_link_master dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .link_clock_out(l_clk), .link_data_in(link_wire), .link_data_out(m_dat), .link_data_oe_out(m_oe),
    .companion_irq_n_in(irq_n), .busy_cleared_irq_out(bc_irq), .link_error_irq_out(err_irq),
    .companion_irq_n_out(irq_n_out));
  clm_companion comp_u (.clk_in(l_clk), .dat_in(link_wire), .mute_in(mute), .bad_in(bad),
    .oe_out(c_oe), .dat_out(c_dat));
  ////////////////////////////////////////////////////////////
  // clock and busy-cleared pulse counter
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (bc_irq === 1'b1) pulses <= pulses + 1;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one strobe cycle; read data is taken well after it has settled
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk_in);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr = a;
    wdata = d;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    @(negedge sys_clk_in);
    got = rdata;
  endtask
  // bounded busy poll; a hang ends the run
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      acc(1'b0, OFS_STATUS, 32'h0);
      if (got[ST_BUSY_BIT] === 1'b0) return;
    end
    miscompares++;
    $display("[FAIL] %0t busy never cleared", $time);
    finish_test();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h81);
    wait_idle();
    chk(got, 32'h0);
    chk(pulses, 0);
    acc(1'b0, OFS_DIVIDER, 32'h0);
    chk(got, 32'h4);
    acc(1'b0, 8'h10, 32'h0);
    chk(got, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_write();
    acc(1'b1, OFS_STATUS, 32'h10);
    acc(1'b1, OFS_ADDRESS, 32'h5a);
    p = pulses;
    acc(1'b1, OFS_DATA, 32'hc3);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h11);
    wait_idle();
    chk(comp_u.mem[8'h5a], 8'hc3);
    chk(pulses - p, 1);
    $display("write test done");
  endtask
  task automatic t_read();
    comp_u.mem[8'h21] = 8'h96;
    acc(1'b1, OFS_ADDRESS, 32'h21);
    acc(1'b0, OFS_DATA, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h11);
    p = pulses;
    wait_idle();
    chk(pulses - p, 1);
    acc(1'b0, OFS_DATA, 32'h0);
    chk(got, 32'h96);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h10);
    $display("read test done");
  endtask
  task automatic t_error();
    mute = 1'b1;
    acc(1'b1, OFS_STATUS, 32'h30);
    acc(1'b1, OFS_DATA, 32'h11);
    wait_idle();
    chk(got, 32'h70);
    chk(err_irq, 1);
    acc(1'b1, OFS_STATUS, 32'h30);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h70);
    acc(1'b1, OFS_STATUS, 32'h70);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'h30);
    mute = 1'b0;
    p = pulses;
    acc(1'b1, OFS_STATUS, 32'hb0);
    acc(1'b1, OFS_DIVIDER, 32'h9);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(got, 32'hb1);
    wait_idle();
    chk(pulses - p, 0);
    acc(1'b1, OFS_DIVIDER, 32'h5);
    acc(1'b0, OFS_DIVIDER, 32'h0);
    chk(got, 32'h9);
    $display("error test done");
  endtask
  // read reply with a corrupted crc: recovery, error flag, then soft reset
  task automatic t_crc();
    bad = 1'b1;
    p = pulses;
    acc(1'b1, OFS_ADDRESS, 32'h21);
    acc(1'b0, OFS_DATA, 32'h0);
    wait_idle();
    chk(got, 32'h70);
    chk(pulses - p, 1);
    bad = 1'b0;
    acc(1'b1, OFS_STATUS, 32'hf0);
    wait_idle();
    chk(got, 32'h30);
    $display("crc error test done");
  endtask
  task automatic t_irq();
    irq_n = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    chk(irq_n_out, 0);
    irq_n = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    chk(irq_n_out, 1);
    $display("companion request test done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, mute, bad, reg_addr, wdata} = '0;
    irq_n = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_error();
    t_crc();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
